/* File: brg_pkg.sv */
// Constants and types for the bus reset and gap count control block.
// Summary of operation
// R1: Writing a one to bus_reset_initiate starts a bus reset and its initialization sequence; outside BRG_IDLE the code ignores only the initiate bit.
// R2: bus_reset_initiate shares register 1 with root_holdoff_flag and gap count, so one write sets all three; a same-cycle packet overrides flag and gap.
// R3: Root_holdoff_flag and gap count load from every received and every transmitted PHY-config packet; if both come in one cycle, only cfg_tx loads.
// R4: Two consecutive bus resets with no gap count update in between force the gap count to 63.
// R5: A bus reset started by a register 1 write keeps the gap count just written.
// R6: After sending a PHY-config packet software starts a bus reset with matching register 1 values.
// R7: Any other initiate write carries a gap count of 63 and the unchanged root_holdoff_flag.
// R8: Software writes register 1 only to set bus_reset_initiate.
// R9: The gap count field is six bits wide, holding up to 63.
// R10: A flag records any gap count update since the last bus reset and clears the reset tracking.
`default_nettype none
package brg_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [3:0] BRG_REG_CONTROL = 4'h1;
    localparam logic [3:0] BRG_REG_STATUS = 4'h2;
    localparam int BRG_BIT_ROOT_HOLDOFF = 7;
    localparam int BRG_BIT_INITIATE = 6;
    localparam logic [5:0] BRG_GAP_MAX = 6'h3f;
    localparam logic BRG_RHF_RESET = 1'b0;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int BRG_CLK_NS = 50;
    localparam int BRG_RESET_NS = 200;
    localparam int BRG_RESET_CYCLES = BRG_RESET_NS / BRG_CLK_NS;
    localparam int BRG_INIT_NS = 200;
    localparam int BRG_INIT_CYCLES = BRG_INIT_NS / BRG_CLK_NS;

    typedef struct packed {
        logic valid;
        logic root_holdoff_flag;
        logic [5:0] gap_count;
    } brg_cfg_t;

    typedef enum logic [1:0] {
        BRG_IDLE = 2'b00,
        BRG_RESET = 2'b01,
        BRG_INIT = 2'b11
    } brg_state_t;
endpackage
`default_nettype wire

/* File: brg_ctrl.sv */
// Bus reset start, root holdoff flag and gap count keeper.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module brg_ctrl
    import brg_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire brg_cfg_t cfg_rx,
    input wire brg_cfg_t cfg_tx,
    input wire logic bus_reset_seen,
    output logic bus_reset_active,
    output logic init_active,
    output logic root_holdoff_flag,
    // R9: six bit gap count
    output logic [5:0] gap_count
);
    // --------------------------------------------------------------
    // Register decode
    // --------------------------------------------------------------
    wire ctl_wr = reg_wr && (reg_addr == BRG_REG_CONTROL);
    // R1: start on initiate
    wire start_req = ctl_wr && reg_wdata[BRG_BIT_INITIATE];
    // R10: update detection
    wire gap_load = ctl_wr || cfg_rx.valid || cfg_tx.valid;
    brg_state_t state;
    brg_state_t next_state;
    logic [2:0] cnt;
    logic updated;
    logic reset_pending;
    wire reset_done = (state == BRG_RESET) &&
        (cnt == 3'(BRG_RESET_CYCLES - 1));
    wire reset_event = reset_done || bus_reset_seen;
    wire [7:0] ctl_value = {root_holdoff_flag, 1'b0, gap_count};
    wire [7:0] status_value = {5'h00, updated, init_active,
        bus_reset_active};
    wire [7:0] next_rdata = !reg_rd ? 8'h00 :
        (reg_addr == BRG_REG_CONTROL) ? ctl_value :
        (reg_addr == BRG_REG_STATUS) ? status_value : 8'h00;

    assign bus_reset_active = (state == BRG_RESET);
    assign init_active = (state == BRG_INIT);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // --------------------------------------------------------------
    // Reset and initialization sequencer
    // --------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            BRG_IDLE: begin
                if (start_req) begin
                    next_state = BRG_RESET;
                end
            end
            BRG_RESET: begin
                if (reset_done) begin
                    next_state = BRG_INIT;
                end
            end
            BRG_INIT: begin
                if (cnt == 3'(BRG_INIT_CYCLES - 1)) begin
                    next_state = BRG_IDLE;
                end
            end
            default: next_state = BRG_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= BRG_IDLE;
            cnt <= 3'h0;
        end else begin
            state <= next_state;
            cnt <= (next_state != state) ? 3'h0 : cnt + 3'h1;
        end
    end

    // --------------------------------------------------------------
    // Root holdoff flag and gap count
    // --------------------------------------------------------------
    // Packets win over a register write in the same cycle; the
    // transmitted packet wins over a received one.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            root_holdoff_flag <= BRG_RHF_RESET;
            gap_count <= BRG_GAP_MAX;
        end else if (cfg_tx.valid) begin
            // R3: load on transmit
            root_holdoff_flag <= cfg_tx.root_holdoff_flag;
            gap_count <= cfg_tx.gap_count;
        end else if (cfg_rx.valid) begin
            // R3: load on receive
            root_holdoff_flag <= cfg_rx.root_holdoff_flag;
            gap_count <= cfg_rx.gap_count;
        end else if (ctl_wr) begin
            // R2: shared register write
            root_holdoff_flag <= reg_wdata[BRG_BIT_ROOT_HOLDOFF];
            gap_count <= reg_wdata[5:0];
        end else if (reset_event && !updated && reset_pending) begin
            // R4: fallback to maximum
            gap_count <= BRG_GAP_MAX;
        end
    end

    // R10: consecutive reset tracking
    // R5: written value survives own reset
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            updated <= 1'b0;
            reset_pending <= 1'b0;
        end else if (gap_load) begin
            updated <= 1'b1;
            reset_pending <= 1'b0;
        end else if (reset_event) begin
            // A reset with no update since the previous reset is the
            // second of a consecutive pair and triggers the fallback.
            updated <= 1'b0;
            reset_pending <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: brg_ctrl_sva.sv */
// Checker for bus reset start and gap count keeping.
`default_nettype none
module brg_ctrl_sva
    import brg_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire brg_cfg_t cfg_rx,
    input wire brg_cfg_t cfg_tx,
    input wire logic bus_reset_seen,
    input wire logic bus_reset_active,
    input wire logic init_active,
    input wire logic root_holdoff_flag,
    input wire logic [5:0] gap_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic wr1 = reg_wr && reg_addr == BRG_REG_CONTROL;
    wire logic cf = cfg_rx.valid || cfg_tx.valid;
    wire logic ld = wr1 || cf;
    wire logic go = wr1 && reg_wdata[BRG_BIT_INITIATE] && !cf
        && !bus_reset_active && !init_active && !bus_reset_seen;
    a_reset_seq: assert property (go |=>
        bus_reset_active[*4] ##1 init_active[*4] ##1 !init_active)
        else $error("reset sequence wrong");
    a_write_fields: assert property (wr1 && !cf |=>
        {root_holdoff_flag, 1'b0, gap_count} == ($past(reg_wdata) & 8'hbf))
        else $error("register write not taken");
    a_tx_load: assert property (cfg_tx.valid |=>
        {root_holdoff_flag, gap_count} == $past(cfg_tx[6:0]))
        else $error("sent config not loaded");
    a_rx_load: assert property (cfg_rx.valid && !cfg_tx.valid |=>
        {root_holdoff_flag, gap_count} == $past(cfg_rx[6:0]))
        else $error("received config not loaded");
    a_gap_fallback: assert property (bus_reset_seen && !ld ##1
        (!ld && !bus_reset_seen && !bus_reset_active)[*3] ##1
        (bus_reset_seen && !ld) |=> gap_count == BRG_GAP_MAX)
        else $error("gap count did not fall back");
    a_gap_kept: assert property (go |->
        ##9 gap_count == $past(reg_wdata[5:0], 9))
        else $error("written gap count lost");
    a_gap_cause: assert property ($changed(gap_count) &&
        gap_count != BRG_GAP_MAX |-> $past(ld))
        else $error("gap count changed without load");
    cover property (go);
    cover property (cfg_rx.valid);
    cover property (bus_reset_seen && gap_count == BRG_GAP_MAX);
endmodule
bind brg_ctrl brg_ctrl_sva u_sva (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .cfg_rx, .cfg_tx, .bus_reset_seen, .bus_reset_active,
    .init_active, .root_holdoff_flag, .gap_count);
`default_nettype wire

/* File: brg_peer.sv */
// Peer node model that sends config packets and cable resets.
`default_nettype none
module brg_peer
    import brg_pkg::*;
(
    input wire logic core_clk,
    input wire logic cfg_go,
    input wire logic rst_go,
    input wire logic [6:0] cfg_val,
    output var brg_cfg_t cfg_rx,
    output var logic bus_reset_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fields are scrambled outside a packet so stale values never help.
    always_ff @(posedge core_clk) begin
        cfg_rx <= cfg_go ? {1'b1, cfg_val} : {1'b0, ~cfg_val};
        bus_reset_seen <= rst_go;
    end
endmodule
`default_nettype wire

/* File: phy_bus_reset_gap_control_bench.sv */
// Self-checking bench for the bus reset and gap count block.
`default_nettype none
module phy_bus_reset_gap_control_bench
    import brg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic cfg_go = 1'b0, rst_go = 1'b0, bus_reset_seen, bus_reset_active;
    logic init_active, root_holdoff_flag;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [6:0] cfg_val = 7'h00;
    logic [5:0] gap_count;
    brg_cfg_t cfg_tx = '0, cfg_rx;
    int fails = 0, total_checks = 0, cyc = 0;
    brg_ctrl u_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cfg_rx, .cfg_tx, .bus_reset_seen,
        .bus_reset_active, .init_active, .root_holdoff_flag, .gap_count);
    brg_peer u_peer (.core_clk, .cfg_go, .rst_go, .cfg_val, .cfg_rx,
        .bus_reset_seen);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 400) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(string w, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic nap(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task automatic t_init();
        wr(4'h1, 8'hc5);
        nap(0);
        chk("state", 8'hc5, {root_holdoff_flag, bus_reset_active, gap_count});
        nap(4);
        chk("init", 8'h01, {7'h00, init_active});
        rd(4'h2, 8'h02);
        nap(3);
        rd(4'h1, 8'h85);
        rd(4'h3, 8'h00);
        $display("init test done");
    endtask
    task automatic t_cfg();
        cfg_tx <= 8'h8a;
        nap(1);
        cfg_tx <= '0;
        chk("tx", 8'h0a, {root_holdoff_flag, 1'b0, gap_count});
        cfg_val <= 7'h47;
        cfg_go <= 1'b1;
        nap(1);
        cfg_go <= 1'b0;
        nap(1);
        chk("rx", 8'h87, {root_holdoff_flag, 1'b0, gap_count});
        rd(4'h1, 8'h87);
        wr(4'h1, 8'hc7);
        nap(9);
        rd(4'h1, 8'h87);
        $display("config test done");
    endtask
    task automatic t_fall();
        cfg_val <= 7'h11;
        cfg_go <= 1'b1;
        nap(1);
        cfg_go <= 1'b0;
        rst_go <= 1'b1;
        nap(1);
        rst_go <= 1'b0;
        nap(1);
        chk("gap1", 8'h11, {2'b00, gap_count});
        nap(2);
        rst_go <= 1'b1;
        nap(1);
        rst_go <= 1'b0;
        nap(1);
        chk("gap2", 8'h3f, {2'b00, gap_count});
        wr(4'h1, 8'h7f);
        nap(9);
        rd(4'h1, 8'h3f);
        $display("fallback test done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        t_init();
        t_cfg();
        t_fall();
        stop_test();
    end
endmodule
`default_nettype wire
